// *** src/ccsr_core.sv ***
// Core phase sequencer, fetch pipeline and special register bank
`timescale 1ns/1ps
module ccsr_core #(
  parameter int  PROG_WORDS = 256
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          clk_en,
  input  wire logic                          power_on_event,
  input  wire logic                          warm_reset_event,
  input  wire logic [ccsr_pkg::WORD_W-1:0]   prog_word,
  input  wire logic                          branch_req,
  input  wire logic [ccsr_pkg::PC_W-1:0]     branch_target,
  input  wire logic                          option_load,
  input  wire logic [ccsr_pkg::DATA_W-1:0]   working_reg,
  input  wire logic                          direction_load,
  input  wire logic                          file_write,
  input  wire logic [ccsr_pkg::FADDR_W-1:0]  file_addr,
  input  wire logic [ccsr_pkg::DATA_W-1:0]   file_wdata,
  input  wire logic [ccsr_pkg::DATA_W-1:0]   ext_rdata,
  input  wire logic [ccsr_pkg::DATA_W-1:0]   timer_value,
  input  wire logic [ccsr_pkg::DATA_W-1:0]   flags_value,
  input  wire logic [ccsr_pkg::PIN_N-1:0]    pin_in,
  output logic [1:0]                         phase,
  output logic                               phase_first,
  output logic                               phase_second,
  output logic                               phase_third,
  output logic                               phase_fourth,
  output logic [ccsr_pkg::PC_W-1:0]          prog_addr,
  output logic [ccsr_pkg::WORD_W-1:0]        instruction_holding_register,
  output logic                               exec_valid,
  output logic [ccsr_pkg::DATA_W-1:0]        operand,
  output logic [ccsr_pkg::DATA_W-1:0]        ext_addr,
  output logic                               ext_write,
  output logic [ccsr_pkg::DATA_W-1:0]        ext_wdata,
  output logic [ccsr_pkg::DATA_W-1:0]        timer_options,
  output logic [ccsr_pkg::PIN_N-1:0]         pin_out,
  output logic [ccsr_pkg::PIN_N-1:0]         pin_oe_n,
  output logic [ccsr_pkg::PIN_N-1:0]         pullup_en,
  output logic [ccsr_pkg::PIN_N-1:0]         wake_en,
  output logic                               timer_ext_clock,
  output logic                               timer_falling_edge,
  output logic                               prescaler_to_watchdog,
  output logic [ccsr_pkg::DATA_W:0]          timer_divide,
  output logic [ccsr_pkg::DATA_W-1:0]        watchdog_divide
);
  import ccsr_pkg::*;

  ccsr_phase_t                 ph;
  logic [PC_W-1:0]             program_counter;
  logic [DATA_W-1:0]           indirect_pointer;
  logic [DATA_W-1:0]           oscillator_trim;
  logic [DATA_W-1:0]           comparator_control;
  logic [PIN_N-1:0]            port_latch;
  logic [PIN_N-1:0]            port_direction;
  logic [DATA_W-1:0]           opt_pending;
  logic                        opt_pending_v;
  logic                        flush;
  logic [PIN_N-1:0]            pin_s1;
  logic [PIN_N-1:0]            pin_s2;
  logic [PIN_N-1:0]            pin_s3;
  logic [PIN_N-1:0]            pin_clean;

  // Phase decode
  wire run       = clk_en;
  wire at_first  = (ph == PH_FIRST);
  wire at_second = (ph == PH_SECOND);
  wire at_fourth = (ph == PH_FOURTH);
  wire any_reset = power_on_event | warm_reset_event;

  wire [PC_W-1:0] pc_plus   = program_counter + 9'h001;
  wire [PC_W-1:0] pc_limit  = (PROG_WORDS <= 256) ? PC_WRAP_MASK : 9'h1ff;
  wire [PC_W-1:0] fetch_addr = program_counter & pc_limit;

  // indirect window resolves to the pointer target
  wire            is_indirect = (file_addr == ADDR_INDIRECT);
  wire [7:0]      eff_addr    = is_indirect ? indirect_pointer
                                            : {3'h0, file_addr};
  wire            eff_local   = (eff_addr[7:5] == 3'h0) ||
                                (eff_addr[4:0] < 5'h08);
  wire [4:0]      eff_reg     = is_indirect ? indirect_pointer[4:0]
                                            : file_addr;

  // port reads use the filtered pins, upper nibble zero
  wire [7:0] port_read = {4'h0, pin_clean};

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = ext_rdata;
    if (eff_reg < 5'h08) begin
      unique case (eff_reg[2:0])
        3'h0: rd_mux = 8'h00;
        3'h1: rd_mux = timer_value;
        // only the low counter byte is visible
        3'h2: rd_mux = program_counter[7:0];
        3'h3: rd_mux = flags_value;
        3'h4: rd_mux = indirect_pointer;
        3'h5: rd_mux = oscillator_trim;
        3'h6: rd_mux = port_read;
        3'h7: rd_mux = comparator_control;
      endcase
    end
  end

  wire wr_now  = run && at_fourth && file_write && exec_valid;
  wire wr_reg  = wr_now && eff_local && (eff_reg < 5'h08);
  wire wr_pcl  = wr_reg && (eff_reg == ADDR_PCL);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph <= PH_FIRST;
    end else if (run) begin
      if (any_reset)
        ph <= PH_FIRST;
      else
        ph <= ccsr_phase_t'(ph + 2'd1);
    end
  end

  // Three-stage pin filter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1    <= 4'h0;
      pin_s2    <= 4'h0;
      pin_s3    <= 4'h0;
      pin_clean <= 4'h0;
    end else if (run) begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
    end
  end

  // Program counter and fetch pipeline
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      program_counter              <= RST_PC;
      instruction_holding_register <= RST_WORD;
      exec_valid                   <= 1'b0;
      flush                        <= 1'b0;
      prog_addr                    <= RST_PC;
    end else if (run) begin
      if (any_reset) begin
        program_counter <= RST_PC;
        exec_valid      <= 1'b0;
        flush           <= 1'b0;
      end else if (at_first) begin
        program_counter <= pc_plus & pc_limit;
        prog_addr       <= fetch_addr;
      end else if (at_fourth) begin
        instruction_holding_register <= prog_word;
        // flush word fetched under a branch
        exec_valid <= !(flush || (exec_valid && (branch_req || wr_pcl)));
        flush      <= 1'b0;
        if (exec_valid && branch_req) begin
          program_counter <= branch_target & pc_limit;
          flush <= 1'b0;
        end else if (wr_pcl) begin
          program_counter <= {1'b0, file_wdata} & pc_limit;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand  <= 8'h00;
      ext_addr <= 8'h00;
    end else if (run && at_second) begin
      operand  <= rd_mux;
      ext_addr <= eff_addr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_write <= 1'b0;
      ext_wdata <= 8'h00;
    end else if (run) begin
      ext_write <= wr_now && !(eff_local && (eff_reg < 5'h08));
      ext_wdata <= file_wdata;
    end
  end

  // Special registers held in this bank
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indirect_pointer   <= RST_POINTER;
      oscillator_trim    <= RST_TRIM;
      comparator_control <= RST_COMP;
      port_latch         <= 4'h0;
      port_direction     <= RST_DIRECTION;
    end else if (run) begin
      if (power_on_event) begin
        indirect_pointer   <= RST_POINTER;
        oscillator_trim    <= RST_TRIM;
        comparator_control <= RST_COMP;
        port_direction     <= RST_DIRECTION;
      end else if (warm_reset_event) begin
        // warm reset keeps pointer, trim and latch
        comparator_control <= RST_COMP;
        port_direction     <= RST_DIRECTION;
      end else if (wr_reg) begin
        unique case (eff_reg[2:0])
          3'h4: indirect_pointer   <= file_wdata | RST_POINTER;
          3'h5: oscillator_trim    <= file_wdata;
          3'h6: port_latch         <= file_wdata[3:0] & PORT_MASK;
          3'h7: comparator_control <= file_wdata;
          default: ;
        endcase
      end else if (run && at_fourth && direction_load && exec_valid) begin
        port_direction <= working_reg[3:0];
      end
    end
  end

  // option load only through the option instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opt_pending   <= RST_OPTION;
      opt_pending_v <= 1'b0;
      timer_options <= RST_OPTION;
    end else if (run) begin
      if (any_reset) begin
        // every reset sets all option bits
        timer_options <= RST_OPTION;
        opt_pending_v <= 1'b0;
      end else if (at_fourth && option_load && exec_valid) begin
        // applied at end of fourth phase
        timer_options <= working_reg;
      end
    end
  end

  // Pin and timer control decode
  wire [3:0] is_output = ~port_direction;
  wire       ext_clk   = timer_options[OPT_CLK_SRC];
  wire [2:0] rate      = timer_options[OPT_RATE_HI:0];
  wire [3:0] tclk_mask = ext_clk ? (4'h1 << TIMER_PIN) : 4'h0;

  // Pin controls and timer configuration outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_out               <= 4'h0;
      pin_oe_n              <= 4'hf;
      pullup_en             <= 4'h0;
      wake_en               <= 4'h0;
      timer_ext_clock       <= 1'b1;
      timer_falling_edge    <= 1'b1;
      prescaler_to_watchdog <= 1'b1;
      timer_divide          <= 9'h100;
      watchdog_divide       <= 8'h80;
      phase                 <= 2'd0;
      phase_first           <= 1'b0;
      phase_second          <= 1'b0;
      phase_third           <= 1'b0;
      phase_fourth          <= 1'b0;
    end else if (run) begin
      pin_out  <= port_latch;
      // timer clock pin forced to input when the external timer clock is selected
      pin_oe_n <= ~(is_output & ~tclk_mask);
      pullup_en <= timer_options[OPT_PULL_DIS] ? 4'h0
                   : (port_direction & WAKE_PINS);
      wake_en   <= timer_options[OPT_WAKE_DIS] ? 4'h0
                   : (port_direction & WAKE_PINS);
      timer_ext_clock    <= ext_clk;
      timer_falling_edge <= timer_options[OPT_EDGE_SEL];
      prescaler_to_watchdog <= timer_options[OPT_PS_ASSIGN];
      timer_divide    <= 9'h002 << rate;
      watchdog_divide <= 8'h01 << rate;
      phase        <= ph;
      phase_first  <= at_first;
      phase_second <= at_second;
      phase_third  <= (ph == PH_THIRD);
      phase_fourth <= at_fourth;
    end
  end

endmodule // ccsr_core

// *** src/ccsr_pkg.sv ***
// Constants for the core cycle and special register bank
package ccsr_pkg;
  // Phase sequencer
  typedef enum logic [1:0] {
    PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH
  } ccsr_phase_t;
  // Widths
  localparam int PC_W       = 9;
  localparam int WORD_W     = 12;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 5;
  localparam int PIN_N      = 4;
  // File addresses
  localparam logic [4:0] ADDR_INDIRECT  = 5'h00;
  localparam logic [4:0] ADDR_TIMER     = 5'h01;
  localparam logic [4:0] ADDR_PCL       = 5'h02;
  localparam logic [4:0] ADDR_FLAGS     = 5'h03;
  localparam logic [4:0] ADDR_POINTER   = 5'h04;
  localparam logic [4:0] ADDR_TRIM      = 5'h05;
  localparam logic [4:0] ADDR_PORT      = 5'h06;
  localparam logic [4:0] ADDR_COMP      = 5'h07;
  // Reset values
  localparam logic [8:0] RST_PC         = 9'h000;
  localparam logic [7:0] RST_PCL_POR    = 8'hff;
  localparam logic [7:0] RST_POINTER    = 8'he0;
  localparam logic [7:0] RST_TRIM       = 8'hfe;
  localparam logic [7:0] RST_COMP       = 8'hff;
  localparam logic [7:0] RST_FLAGS      = 8'h18;
  localparam logic [3:0] RST_DIRECTION  = 4'hf;
  localparam logic [7:0] RST_OPTION     = 8'hff;
  localparam logic [11:0] RST_WORD      = 12'h000;
  // Option field positions
  localparam int OPT_WAKE_DIS   = 7;
  localparam int OPT_PULL_DIS   = 6;
  localparam int OPT_CLK_SRC    = 5;
  localparam int OPT_EDGE_SEL   = 4;
  localparam int OPT_PS_ASSIGN  = 3;
  localparam int OPT_RATE_HI    = 2;
  // Pin carrying the external timer clock, and port mask
  localparam int TIMER_PIN      = 2;
  localparam logic [3:0] PORT_MASK = 4'hf;
  localparam logic [3:0] WAKE_PINS = 4'hb;
  localparam logic [8:0] PC_WRAP_MASK = 9'h0ff;
endpackage

// *** verification/ccsr_assertions.sv ***
// Port-level assertions for the core cycle and special register bank
`timescale 1ns/1ps
module ccsr_checker
  import ccsr_pkg::*;
#(
  parameter int PROG_WORDS = 256
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic       power_on_event,
  input wire logic       warm_reset_event,
  input wire logic       option_load,
  input wire logic [7:0] working_reg,
  input wire logic [1:0] phase,
  input wire logic [8:0] prog_addr,
  input wire logic [7:0] timer_options,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] pullup_en,
  input wire logic [3:0] wake_en,
  input wire logic       timer_ext_clock,
  input wire logic       timer_falling_edge,
  input wire logic       prescaler_to_watchdog,
  input wire logic [8:0] timer_divide,
  input wire logic [7:0] watchdog_divide
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A full instruction cycle with the option request held
  sequence s_opt_cycle;
    (option_load && clk_en)[*4];
  endsequence
  // Options and direction settled long enough for derived outputs
  sequence s_settled;
    $stable(timer_options) && $stable(pin_oe_n);
  endsequence
  // Phase output lags the sequencer, so an advance shows two edges later
  a_phase_step: assert property (clk_en && !power_on_event
    && !warm_reset_event ##1 clk_en |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance by one");
  a_option_load: assert property (
    s_opt_cycle |=> timer_options == $past(working_reg))
    else $error("option value not loaded");
  a_option_reset: assert property (
    warm_reset_event && clk_en |=> timer_options == RST_OPTION)
    else $error("options not all ones after reset");
  a_rate_divide: assert property ($stable(timer_options) |->
    timer_divide == (9'h002 << timer_options[2:0])
    && watchdog_divide == (8'h01 << timer_options[2:0]))
    else $error("prescaler divide wrong");
  a_source_bits: assert property ($stable(timer_options) |->
    {timer_ext_clock, timer_falling_edge, prescaler_to_watchdog}
    == timer_options[5:3])
    else $error("timer source bits wrong");
  a_pullup_mask: assert property (s_settled |-> pullup_en ==
    (~{4{timer_options[OPT_PULL_DIS]}} & pin_oe_n & WAKE_PINS))
    else $error("pull-up enables wrong");
  a_wake_mask: assert property (s_settled |-> wake_en ==
    (~{4{timer_options[OPT_WAKE_DIS]}} & pin_oe_n & WAKE_PINS))
    else $error("wake enables wrong");
  a_timer_pin_input: assert property (s_settled
    and timer_options[OPT_CLK_SRC] |-> pin_oe_n[TIMER_PIN])
    else $error("timer clock pin driven");
  a_addr_wrap: assert property (PROG_WORDS == 256 |->
    prog_addr[8] == 1'b0)
    else $error("address above implemented space");
  a_restart_zero: assert property (
    warm_reset_event && clk_en |-> ##[1:5] prog_addr == RST_PC)
    else $error("no restart at address zero");
endmodule // ccsr_checker

// *** verification/ccsr_core_test.sv ***
// Self-checking bench for the core cycle and special register bank
`timescale 1ns/1ps
module ccsr_core_test;
  import ccsr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic power_on_event = 1'b0, warm_reset_event = 1'b0;
  logic branch_req = 1'b0, option_load = 1'b0;
  logic direction_load = 1'b0, file_write = 1'b0;
  logic [11:0] prog_word = 12'h000;
  logic [8:0]  branch_target = 9'h000;
  logic [7:0]  working_reg = 8'h00, file_wdata = 8'h00;
  logic [7:0]  ext_rdata = 8'h3c, timer_value = 8'h5a;
  logic [7:0]  flags_value = 8'h18;
  logic [4:0]  file_addr = 5'h00;
  logic [3:0]  pin_in = 4'hf;
  logic [1:0]  phase;
  logic        phase_first, phase_second, phase_third, phase_fourth;
  logic        exec_valid, ext_write, timer_ext_clock;
  logic        timer_falling_edge, prescaler_to_watchdog, fl;
  logic [8:0]  prog_addr, timer_divide;
  logic [11:0] instruction_holding_register;
  logic [7:0]  operand, ext_addr, ext_wdata, timer_options;
  logic [7:0]  watchdog_divide;
  logic [3:0]  pin_out, pin_oe_n, pullup_en, wake_en;
  int          n_mismatch = 0, num_checks = 0;

  ccsr_core #(.PROG_WORDS(256)) u_dut (.*);

  // Free-running clock, 50 ns period
  always #25 clk = ~clk;

  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic clocks(int n);
    repeat (n) @(negedge clk);
  endtask
  // Hold a request for exactly one instruction cycle
  task automatic op(ref logic sig);
    sig = 1'b1;
    clocks(4);
    sig = 1'b0;
  endtask
  task automatic rd(logic [4:0] a);
    file_addr = a;
    clocks(4);
  endtask

  task automatic t_reset;
    check("options", timer_options, 8'hff);
    check("tdiv", timer_divide, 9'h100);
    check("wdiv", watchdog_divide, 8'h80);
    check("oe", pin_oe_n, 4'hf);
    check("pc", prog_addr, 9'h000);
    $display("test reset done");
  endtask
  task automatic t_option;
    logic [7:0] v;
    for (int n = 0; n < 8; n++) begin
      v = {n[1], n[0], n[2], n[1], n[0], n[2:0]};
      working_reg = v;
      op(option_load);
      clocks(2);
      check("options", timer_options, v);
      check("tdiv", timer_divide, 9'h002 << n);
      check("wdiv", watchdog_divide, 8'h01 << n);
      check("src", timer_ext_clock, v[5]);
      check("edge", timer_falling_edge, v[4]);
      check("psa", prescaler_to_watchdog, v[3]);
    end
    $display("test option done");
  endtask
  task automatic t_pins;
    working_reg = 8'h00;
    op(option_load);
    working_reg = 8'h03;
    op(direction_load);
    clocks(2);
    check("oe", pin_oe_n, 4'h3);
    check("pull", pullup_en, 4'h3);
    check("wake", wake_en, 4'h3);
    working_reg = 8'he0;
    op(option_load);
    clocks(2);
    check("oe", pin_oe_n, 4'h7);
    check("pull", pullup_en, 4'h0);
    check("wake", wake_en, 4'h0);
    $display("test pins done");
  endtask
  task automatic t_file;
    // Point past the special registers so the window reaches general RAM
    file_addr = ADDR_POINTER;
    file_wdata = 8'h0c;
    op(file_write);
    rd(ADDR_POINTER);
    check("ptr", operand, 8'hec);
    rd(ADDR_INDIRECT);
    check("ind", operand, 8'h3c);
    check("iaddr", ext_addr, 8'hec);
    rd(ADDR_PORT);
    check("port", operand[7:4], 4'h0);
    check("pins", operand[3:0], 4'hf);
    rd(ADDR_TIMER);
    check("tmr", operand, 8'h5a);
    rd(ADDR_COMP);
    check("comp", operand, 8'hff);
    $display("test file done");
  endtask
  task automatic t_branch;
    // bench only feeds program words, never rewrites the top one
    prog_word = 12'ha5c;
    clocks(8);
    check("ir", instruction_holding_register, 12'ha5c);
    branch_target = 9'h1f0;
    op(branch_req);
    fl = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (exec_valid === 1'b0) fl = 1'b1;
    end
    check("flush", fl, 1'b1);
    check("wrap", prog_addr[8:4], 5'h0f);
    $display("test branch done");
  endtask
  task automatic t_warm;
    working_reg = 8'h00;
    op(option_load);
    file_addr = ADDR_TRIM;
    file_wdata = 8'h12;
    op(file_write);
    warm_reset_event = 1'b1;
    clocks(1);
    warm_reset_event = 1'b0;
    check("options", timer_options, 8'hff);
    clocks(4);
    check("pc", prog_addr[8:1], 8'h00);
    rd(ADDR_TRIM);
    check("trim", operand, 8'h12);
    power_on_event = 1'b1;
    clocks(1);
    power_on_event = 1'b0;
    rd(ADDR_TRIM);
    rd(ADDR_TRIM);
    check("trim", operand, 8'hfe);
    $display("test warm reset done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    #(50 * 3000);
    n_mismatch++;
    print_verdict;
  end
  // Main sequence
  initial begin
    clocks(2);
    t_reset;
    nrst = 1'b1;
    // First fourth phase only fills the pipeline; requests start after it
    clocks(6);
    t_option;
    t_pins;
    t_file;
    t_branch;
    t_warm;
    print_verdict;
  end
endmodule // ccsr_core_test

bind ccsr_core ccsr_checker #(.PROG_WORDS(PROG_WORDS)) u_chk (.*);
